// >>> msps_adc_model.sv
`timescale 1ns/1ps
module msps_adc_model (
  input  wire        clk,
  input  wire        adcStart,
  input  wire [3:0]  adcPort,
  output reg  [11:0] adcSample = 12'h0
);
  // One code per slot, keyed by the port, so a wrong port shows in the result
  always @(posedge clk) begin
    if (adcStart)
      adcSample <= {adcPort, 8'ha5};
  end
endmodule // msps_adc_model

// >>> msps_regs.vh
`ifndef MSPS_REGS_VH
`define MSPS_REGS_VH

// Register byte addresses (Wishbone, 8-bit address, one word each)
`define MSPS_CTRL_ADDR       8'h00
`define MSPS_STATUS_ADDR     8'h04
`define MSPS_MASK_ADDR       8'h08
`define MSPS_OCLIVE_ADDR     8'h0c
`define MSPS_GPIIN_ADDR      8'h10
`define MSPS_GPOSTATE_ADDR   8'h14
`define MSPS_PRESET0_ADDR    8'h18
`define MSPS_PRESET1_ADDR    8'h1c
`define MSPS_PRESETSEL_ADDR  8'h20
// Per-port windows: address bits 7:6 pick the window, bits 5:2 the port
`define MSPS_WIN_CTRL        2'h0
`define MSPS_WIN_CFG         2'h1
`define MSPS_WIN_DACDATA     2'h2
`define MSPS_WIN_ADCDATA     2'h3

// Control register fields
`define MSPS_CTRL_MODE_LSB   0
`define MSPS_CTRL_RATE_LSB   2
`define MSPS_CTRL_JUMP_BIT   4
`define MSPS_CTRL_TRIG_BIT   5
`define MSPS_CTRL_RESET      6'h00

// Converter modes
`define MSPS_MODE_IDLE       2'h0
`define MSPS_MODE_SWEEP1     2'h1
`define MSPS_MODE_CONV1      2'h2
`define MSPS_MODE_CONT       2'h3

// Port configuration fields
`define MSPS_CFG_FN_LSB      0
`define MSPS_CFG_REF_BIT     3
`define MSPS_CFG_DIFF_BIT    4
`define MSPS_CFG_AVG_LSB     5
`define MSPS_CFG_EDGE_LSB    8
`define MSPS_CFG_PAIR_BIT    10
`define MSPS_CFG_RESET       11'h000

// Port functions
`define MSPS_FN_OFF          3'h0
`define MSPS_FN_ADC          3'h1
`define MSPS_FN_DAC          3'h2
`define MSPS_FN_GPI          3'h3
`define MSPS_FN_GPO          3'h4

// Timing
`define MSPS_CLK_PERIOD_PS   25000
`define MSPS_CONVERSION_TRIGGER_N_MIN_NS     500
`define MSPS_DAC_SLOT_NS     40000
`define MSPS_RATE0_SPS       200000
`define MSPS_RATE1_SPS       250000
`define MSPS_RATE2_SPS       333000
`define MSPS_RATE3_SPS       400000
`define MSPS_PIN_RESET       25'h1000000

`endif

// >>> msps_sequencer.v
`timescale 1ns/1ps
`include "msps_regs.vh"
module msps_sequencer (
  input  wire        clk,
  input  wire        resetn,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        conversionTriggerN,
  output reg         adcStart,
  output reg  [3:0]  adcPort,
  output reg         adcRefSel,
  output reg         adcDiff,
  input  wire [11:0] adcSample,
  output reg         dacLoad,
  output reg  [3:0]  dacPort,
  output reg  [11:0] dacCode,
  input  wire [11:0] logicInputLevel,
  output reg  [11:0] logicOutputState,
  input  wire [11:0] overcurrent,
  output wire [10:0] translatorPair,
  input  wire        intNIn,
  output wire        intNOut,
  output wire        intNOe
);

  // Counts worked out at full width, then cut to the counter widths
  localparam integer CONVERSION_TRIGGER_N_N  = ((`MSPS_CONVERSION_TRIGGER_N_MIN_NS * 1000) + `MSPS_CLK_PERIOD_PS - 1)
                               / `MSPS_CLK_PERIOD_PS;
  localparam integer DAC_N   = (`MSPS_DAC_SLOT_NS * 1000) / `MSPS_CLK_PERIOD_PS;
  localparam integer RATE0_N = (1000000000 / `MSPS_RATE0_SPS) * 1000 / `MSPS_CLK_PERIOD_PS;
  localparam integer RATE1_N = (1000000000 / `MSPS_RATE1_SPS) * 1000 / `MSPS_CLK_PERIOD_PS;
  localparam integer RATE2_N = (1000000000 / `MSPS_RATE2_SPS) * 1000 / `MSPS_CLK_PERIOD_PS;
  localparam integer RATE3_N = (1000000000 / `MSPS_RATE3_SPS) * 1000 / `MSPS_CLK_PERIOD_PS;
  localparam [7:0]  CONVERSION_TRIGGER_N_CYC  = CONVERSION_TRIGGER_N_N[7:0];
  localparam [10:0] DAC_CYC   = DAC_N[10:0];
  localparam [7:0]  RATE0_CYC = RATE0_N[7:0];
  localparam [7:0]  RATE1_CYC = RATE1_N[7:0];
  localparam [7:0]  RATE2_CYC = RATE2_N[7:0];
  localparam [7:0]  RATE3_CYC = RATE3_N[7:0];
  localparam [1:0]  S_REST = 2'b01;
  localparam [1:0]  S_SLOT = 2'b10;

  reg  [1:0]  adcMode;
  reg  [1:0]  rateSel;
  reg         jumpEn;
  reg  [11:0] preset0;
  reg  [11:0] preset1;
  reg  [11:0] presetEn;
  reg  [11:0] presetChoice;
  reg  [11:0] gpoState;
  reg  [11:0] ocFlag;
  reg  [11:0] edgeFlag;
  reg  [23:0] irqMask;
  reg  [10:0] portCfg [0:11];
  reg  [11:0] dacData [0:11];
  reg  [11:0] adcData [0:11];
  reg  [18:0] accMem  [0:11];
  reg  [6:0]  cntMem  [0:11];
  reg  [24:0] pinS1;
  reg  [24:0] pinS2;
  reg  [24:0] pinS3;
  reg  [24:0] pinStable;
  reg  [11:0] gpiPrev;
  reg  [7:0]  lowCnt;
  reg  [1:0]  adcState;
  reg  [3:0]  adcPos;
  reg  [3:0]  seqPos;
  reg  [7:0]  adcCnt;
  reg  [10:0] dacCnt;
  reg  [3:0]  dacPos;
  reg         jumpPending;
  reg         trigHold;
  reg  [3:0]  jumpPort;
  reg  [31:0] next_rdata;
  integer     k;

  wire [11:0] adcMask;
  wire [11:0] relMask;
  wire [11:0] gpiMask;
  wire [11:0] gpoMask;
  wire [11:0] riseEn;
  wire [11:0] fallEn;

  // Per-port decode of the configuration word
  genvar g;
  generate
    for (g = 0; g < 12; g = g + 1) begin : gPort
      wire [2:0] fn = portCfg[g][`MSPS_CFG_FN_LSB +: 3];
      assign adcMask[g] = (fn == `MSPS_FN_ADC);
      assign gpiMask[g] = (fn == `MSPS_FN_GPI);
      assign gpoMask[g] = (fn == `MSPS_FN_GPO);
      // Threshold and high level both come from the output converter
      assign relMask[g] = (fn == `MSPS_FN_DAC) | gpiMask[g] | gpoMask[g];
      assign riseEn[g]  = portCfg[g][`MSPS_CFG_EDGE_LSB];
      assign fallEn[g]  = portCfg[g][`MSPS_CFG_EDGE_LSB + 1];
      if (g < 11) begin : gPair
        if (g == 5) begin : gSplit
          assign translatorPair[g] = 1'b0; // Pair would straddle the groups
        end else begin : gJoin
          assign translatorPair[g] = portCfg[g][`MSPS_CFG_PAIR_BIT];
        end
      end
    end
  endgenerate

  // Lowest set index at or above start; bit 4 flags a find
  function [4:0] firstFrom;
    input [11:0] m;
    input [4:0]  start;
    integer i;
    begin
      firstFrom = 5'h00;
      for (i = 11; i >= 0; i = i - 1) begin
        if (m[i] && (i >= start)) begin
          firstFrom = {1'b1, i[3:0]};
        end
      end
    end
  endfunction

  // Byte-lane merge of write data into a stored word
  function [31:0] merge;
    input [31:0] old;
    input [31:0] dat;
    input [3:0]  sel;
    reg   [31:0] m;
    begin
      m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
      merge = (old & ~m) | (dat & m);
    end
  endfunction

  // Bus decode; a request is served on the edge that raises ack
  wire        busReq  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        busWr   = busReq & wb_we_i;
  wire [1:0]  win     = wb_adr_i[7:6];
  wire [3:0]  pIdx    = wb_adr_i[5:2];
  wire        pOk     = (pIdx < 4'hc);
  wire [31:0] ctrlOld = {26'h0, 1'b0, jumpEn, rateSel, adcMode};
  wire [31:0] ctrlNew = merge(ctrlOld, wb_dat_i, wb_sel_i);
  wire        wrCtrl  = busWr & (wb_adr_i == `MSPS_CTRL_ADDR);
  wire [1:0]  modeNew = ctrlNew[`MSPS_CTRL_MODE_LSB +: 2];
  wire        softTrig = wrCtrl & ctrlNew[`MSPS_CTRL_TRIG_BIT];
  // Only a move into a different active mode wipes results
  wire        modeClear = wrCtrl & (modeNew != adcMode)
                          & (modeNew != `MSPS_MODE_IDLE);
  wire        wrCfg   = busWr & (win == `MSPS_WIN_CFG) & pOk;
  wire [10:0] cfgOld  = pOk ? portCfg[pIdx] : `MSPS_CFG_RESET;
  wire [31:0] cfgMrg  = merge({21'h0, cfgOld}, wb_dat_i, wb_sel_i);
  wire [10:0] cfgNew  = cfgMrg[10:0];
  wire        avgClear = wrCfg & (cfgNew[`MSPS_CFG_AVG_LSB +: 3]
                                  != cfgOld[`MSPS_CFG_AVG_LSB +: 3]);
  wire        wrDac   = busWr & (win == `MSPS_WIN_DACDATA) & pOk;
  wire [11:0] dacOld  = pOk ? dacData[pIdx] : 12'h000;
  wire [31:0] dacMrg  = merge({20'h0, dacOld}, wb_dat_i, wb_sel_i);
  wire [31:0] maskMrg = merge({8'h00, irqMask}, wb_dat_i, wb_sel_i);

  // Pins from the analog side: three stages, a change counts once 2 and 3 agree
  wire [24:0] pinRaw = {conversionTriggerN, overcurrent, logicInputLevel};
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pinS1     <= `MSPS_PIN_RESET;
      pinS2     <= `MSPS_PIN_RESET;
      pinS3     <= `MSPS_PIN_RESET;
      pinStable <= `MSPS_PIN_RESET;
      gpiPrev   <= 12'h000;
    end else begin
      pinS1     <= pinRaw;
      pinS2     <= pinS1;
      pinS3     <= pinS2;
      pinStable <= (~(pinS2 ^ pinS3) & pinS3) | ((pinS2 ^ pinS3) & pinStable);
      gpiPrev   <= pinStable[11:0];
    end
  end

  wire [11:0] gpiNow  = pinStable[11:0];
  wire [11:0] ocNow   = pinStable[23:12];
  wire        cnvtLow = ~pinStable[24];
  wire [11:0] edgeHit = gpiMask & ((riseEn & gpiNow & ~gpiPrev)
                                 | (fallEn & ~gpiNow & gpiPrev));
  wire [23:0] status  = {edgeFlag, ocFlag};
  wire        pending = |(status & irqMask);

  // Open drain: only ever pulls low
  assign intNOut = 1'b0;
  assign intNOe  = pending;

  // Trigger pin must stay low for the minimum width; one trigger per low phase
  wire cnvtFire = cnvtLow & (lowCnt == CONVERSION_TRIGGER_N_CYC - 8'h01);
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lowCnt <= 8'h00;
    end else if (!cnvtLow) begin
      lowCnt <= 8'h00;
    end else if (lowCnt != CONVERSION_TRIGGER_N_CYC) begin
      lowCnt <= lowCnt + 8'h01;
    end
  end

  // Software registers; hardware-set flags win over a same-cycle clear
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      adcMode      <= `MSPS_MODE_IDLE;
      rateSel      <= 2'h0;            // Slowest rate
      jumpEn       <= 1'b0;
      preset0      <= 12'h000;
      preset1      <= 12'h000;
      presetEn     <= 12'h000;
      presetChoice <= 12'h000;
      gpoState     <= 12'h000;
      irqMask      <= 24'h000000;
      ocFlag       <= 12'h000;
      edgeFlag     <= 12'h000;
      trigHold     <= 1'b0;
      for (k = 0; k < 12; k = k + 1) begin
        portCfg[k] <= `MSPS_CFG_RESET;
        dacData[k] <= 12'h000;
      end
    end else begin
      // Soft trigger acts a cycle later, once the written mode stands
      trigHold <= softTrig;
      if (wrCtrl) begin
        adcMode <= modeNew;
        rateSel <= ctrlNew[`MSPS_CTRL_RATE_LSB +: 2];
        jumpEn  <= ctrlNew[`MSPS_CTRL_JUMP_BIT];
      end
      if (busWr && wb_adr_i == `MSPS_MASK_ADDR)
        irqMask <= maskMrg[23:0];
      if (busWr && wb_adr_i == `MSPS_GPOSTATE_ADDR)
        gpoState <= wb_dat_i[11:0];
      if (busWr && wb_adr_i == `MSPS_PRESET0_ADDR)
        preset0 <= wb_dat_i[11:0];
      if (busWr && wb_adr_i == `MSPS_PRESET1_ADDR)
        preset1 <= wb_dat_i[11:0];
      if (busWr && wb_adr_i == `MSPS_PRESETSEL_ADDR) begin
        presetEn     <= wb_dat_i[11:0];
        presetChoice <= wb_dat_i[23:12];
      end
      if (wrCfg)
        portCfg[pIdx] <= cfgNew;
      if (wrDac)
        dacData[pIdx] <= dacMrg[11:0];
      // Write one to clear; a live condition sets again at once
      ocFlag   <= (ocFlag & ~((busWr && wb_adr_i == `MSPS_STATUS_ADDR)
                  ? wb_dat_i[11:0] : 12'h000)) | (ocNow & relMask);
      edgeFlag <= (edgeFlag & ~((busWr && wb_adr_i == `MSPS_STATUS_ADDR)
                  ? wb_dat_i[23:12] : 12'h000)) | edgeHit;
    end
  end

  // Converter sequencing and averaging
  wire [7:0]  rateCyc = (rateSel == 2'h3) ? RATE3_CYC : (rateSel == 2'h2) ? RATE2_CYC :
                        (rateSel == 2'h1) ? RATE1_CYC : RATE0_CYC;
  wire [4:0]  adcFirst = firstFrom(adcMask, 5'h00);
  wire [4:0]  adcAbove = firstFrom(adcMask, {1'b0, adcPos} + 5'h01);
  wire [4:0]  seqFirst = firstFrom(adcMask, {1'b0, seqPos});
  wire        trig     = cnvtFire | trigHold;
  wire [2:0]  avgSel   = portCfg[adcPos][`MSPS_CFG_AVG_LSB +: 3];
  wire        smpDiff  = portCfg[adcPos][`MSPS_CFG_DIFF_BIT];
  // Converter returns offset binary; differential results flip the MSB
  wire [11:0] smpVal   = smpDiff ? {~adcSample[11], adcSample[10:0]} : adcSample;
  wire [18:0] smpExt   = smpDiff ? {{7{smpVal[11]}}, smpVal} : {7'h00, smpVal};
  wire [18:0] accSum   = accMem[adcPos] + smpExt;
  wire [7:0]  cntNext  = {1'b0, cntMem[adcPos]} + 8'h01;
  wire        blockEnd = (cntNext == (8'h01 << avgSel));
  wire [18:0] avgOut   = accSum >> avgSel;
  wire        slotEnd  = (adcState == S_SLOT) & (adcCnt == 8'h00);

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      adcState  <= S_REST;
      adcPos    <= 4'h0;
      seqPos    <= 4'h0;
      adcCnt    <= 8'h00;
      adcStart  <= 1'b0;
      adcPort   <= 4'h0;
      adcRefSel <= 1'b0;
      adcDiff   <= 1'b0;
      for (k = 0; k < 12; k = k + 1) begin
        adcData[k] <= 12'h000;
        accMem[k]  <= 19'h00000;
        cntMem[k]  <= 7'h00;
      end
    end else begin
      adcStart <= 1'b0;
      if (slotEnd) begin
        if (blockEnd) begin
          adcData[adcPos] <= avgOut[11:0]; // Only whole blocks land
          accMem[adcPos]  <= 19'h00000;
          cntMem[adcPos]  <= 7'h00;
        end else begin
          accMem[adcPos]  <= accSum;
          cntMem[adcPos]  <= cntNext[6:0];
        end
      end
      // Clears follow the sample so a clear in the same cycle wins
      if (avgClear) begin
        adcData[pIdx] <= 12'h000;
        accMem[pIdx]  <= 19'h00000;
        cntMem[pIdx]  <= 7'h00;
      end
      if (modeClear) begin
        for (k = 0; k < 12; k = k + 1) begin
          adcData[k] <= 12'h000;
          accMem[k]  <= 19'h00000;
          cntMem[k]  <= 7'h00;
        end
        seqPos <= 4'h0;
      end
      case (adcState)
        S_REST: begin
          if (wrCtrl) begin
            adcState <= S_REST; // Let the new mode settle for one cycle
          end else if (adcMode == `MSPS_MODE_CONT && adcFirst[4]) begin
            adcPos   <= adcFirst[3:0]; // No trigger needed
            adcState <= S_SLOT;
          end else if (adcMode == `MSPS_MODE_SWEEP1 && trig && adcFirst[4]) begin
            adcPos   <= adcFirst[3:0]; // Sweep starts at lowest port
            adcState <= S_SLOT;
          end else if (adcMode == `MSPS_MODE_CONV1 && trig && adcMask != 12'h000) begin
            adcPos   <= seqFirst[4] ? seqFirst[3:0] : adcFirst[3:0];
            adcState <= S_SLOT;
          end
          adcCnt <= rateCyc - 8'h01;
          if (!wrCtrl && adcMode != `MSPS_MODE_IDLE && adcMask != 12'h000
              && (adcMode == `MSPS_MODE_CONT || trig)) begin
            adcStart <= 1'b1;
            adcPort  <= (adcMode == `MSPS_MODE_CONV1 && seqFirst[4]) ? seqFirst[3:0]
                        : adcFirst[3:0];
          end
        end
        S_SLOT: begin
          adcRefSel <= portCfg[adcPos][`MSPS_CFG_REF_BIT];
          adcDiff   <= smpDiff;
          if (wrCtrl) begin
            adcState <= S_REST; // A mode write abandons the slot
          end else if (!slotEnd) begin
            adcCnt <= adcCnt - 8'h01;
          end else begin
            adcCnt <= rateCyc - 8'h01;
            if (adcMode == `MSPS_MODE_CONT) begin
              // Endless sweep, wrapping to the lowest port
              adcPos   <= adcAbove[4] ? adcAbove[3:0] : adcFirst[3:0];
              adcPort  <= adcAbove[4] ? adcAbove[3:0] : adcFirst[3:0];
              adcStart <= adcFirst[4];
              adcState <= adcFirst[4] ? S_SLOT : S_REST;
            end else if (adcMode == `MSPS_MODE_SWEEP1 && adcAbove[4]) begin
              adcPos   <= adcAbove[3:0]; // Ascending, then stop
              adcPort  <= adcAbove[3:0];
              adcStart <= 1'b1;
            end else begin
              if (adcMode == `MSPS_MODE_CONV1)
                seqPos <= adcAbove[4] ? adcAbove[3:0] : adcFirst[3:0];
              adcState <= S_REST;
            end
          end
        end
        default: adcState <= S_REST;
      endcase
    end
  end

  // Output converter refresh; jump takes the written port next
  wire [4:0]  dacAbove = firstFrom(relMask, {1'b0, dacPos} + 5'h01);
  wire [4:0]  dacFirst = firstFrom(relMask, 5'h00);
  wire [3:0]  dacNext  = jumpPending ? jumpPort
                         : (dacAbove[4] ? dacAbove[3:0] : dacFirst[3:0]);
  wire        jumpReq  = wrDac & jumpEn & relMask[pIdx];
  wire [11:0] nextCode = presetEn[dacNext] ? (presetChoice[dacNext] ? preset1 : preset0)
                         : dacData[dacNext];

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dacCnt      <= DAC_CYC - 11'h001;
      dacPos      <= 4'h0;
      dacLoad     <= 1'b0;
      dacPort     <= 4'h0;
      dacCode     <= 12'h000;
      jumpPending <= 1'b0;
      jumpPort    <= 4'h0;
      logicOutputState <= 12'h000;
    end else begin
      dacLoad          <= 1'b0;
      logicOutputState <= gpoState & gpoMask; // Low state drives zero
      if (dacCnt != 11'h000) begin
        dacCnt <= dacCnt - 11'h001;
      end else begin
        dacCnt <= DAC_CYC - 11'h001; // One port per 40 us slot
        if (relMask != 12'h000 || jumpPending) begin
          dacPos  <= dacNext; // Order resumes from the jumped port
          dacPort <= dacNext;
          dacCode <= nextCode;
          dacLoad <= 1'b1;
        end
      end
      // A fresh jump write wins over consuming the old one
      if (jumpReq) begin
        jumpPending <= 1'b1;
        jumpPort    <= pIdx;
      end else if (dacCnt == 11'h000) begin
        jumpPending <= 1'b0;
      end
    end
  end

  // Read data and ack, one cycle after the request is seen
  always @* begin
    next_rdata = 32'h00000000;
    case (win)
      `MSPS_WIN_CFG:     next_rdata = pOk ? {21'h0, portCfg[pIdx]} : 32'h00000000;
      `MSPS_WIN_DACDATA: next_rdata = {20'h0, dacOld};
      `MSPS_WIN_ADCDATA: next_rdata = pOk ? {20'h0, adcData[pIdx]} : 32'h00000000;
      default: begin
        case (wb_adr_i)
          `MSPS_CTRL_ADDR:      next_rdata = ctrlOld;
          `MSPS_STATUS_ADDR:    next_rdata = {8'h00, status};
          `MSPS_MASK_ADDR:      next_rdata = {8'h00, irqMask};
          `MSPS_OCLIVE_ADDR:    next_rdata = {20'h0, ocNow};
          `MSPS_GPIIN_ADDR:     next_rdata = {20'h0, gpiNow};
          `MSPS_GPOSTATE_ADDR:  next_rdata = {20'h0, gpoState};
          `MSPS_PRESET0_ADDR:   next_rdata = {20'h0, preset0};
          `MSPS_PRESET1_ADDR:   next_rdata = {20'h0, preset1};
          `MSPS_PRESETSEL_ADDR: next_rdata = {8'h00, presetChoice, presetEn};
          default:              next_rdata = 32'h00000000;
        endcase
      end
    endcase
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= busReq;
      if (busReq && !wb_we_i)
        wb_dat_o <= next_rdata;
    end
  end

endmodule // msps_sequencer

// >>> msps_sequencer_asserts.sv
`timescale 1ns/1ps
`include "msps_regs.vh"
module msps_sequencer_asserts (
  input wire        clk,
  input wire        resetn,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [7:0]  wb_adr_i,
  input wire [3:0]  wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire        wb_ack_o,
  input wire        adcStart,
  input wire [3:0]  adcPort,
  input wire        adcRefSel,
  input wire        adcDiff,
  input wire        dacLoad,
  input wire [10:0] translatorPair,
  input wire        intNOut
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  reg        modeSeen;
  reg        dacSeen;
  reg [10:0] dacGap;
  // Request taken by the slave
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // Slot start, then the cycle its settings are valid
  sequence s_slot;
    adcStart ##1 1'h1;
  endsequence
  // First active mode write; saturating count since the last output load
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      modeSeen <= 1'h0;
      dacSeen  <= 1'h0;
      dacGap   <= 11'h0;
    end else begin
      if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0]
          && wb_adr_i == `MSPS_CTRL_ADDR && wb_dat_i[1:0] != `MSPS_MODE_IDLE)
        modeSeen <= 1'h1;
      if (dacLoad)
        dacSeen <= 1'h1;
      dacGap <= dacLoad ? 11'h0 : dacGap + {10'h0, dacGap != 11'h7ff};
    end
  end
  a_bus_ack_once: assert property (s_take |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack is not one pulse a cycle after the request");
  a_idle_no_start: assert property (!modeSeen |-> !adcStart)
    else $error("conversion before any mode was chosen");
  a_slot_min_len: assert property (adcStart |=> !adcStart [*8])
    else $error("conversion slots too close");
  a_adc_port_range: assert property (adcStart |-> adcPort <= 4'hb)
    else $error("conversion on a missing port");
  a_ref_held: assert property (
    s_slot |=> (adcStart || $stable(adcRefSel) && $stable(adcDiff)) [*8])
    else $error("reference or input mode moved inside a slot");
  a_dac_slot_len: assert property (dacLoad && dacSeen |-> dacGap == 11'h63f)
    else $error("output slot is not 1600 cycles");
  a_pair_groups: assert property (translatorPair[5] == 1'h0)
    else $error("translator pair crosses the port groups");
  a_int_open_drain: assert property (intNOut == 1'h0)
    else $error("interrupt pin driven high");
endmodule // msps_sequencer_asserts

bind msps_sequencer msps_sequencer_asserts u_chk (.clk, .resetn, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .adcStart, .adcPort, .adcRefSel,
  .adcDiff, .dacLoad, .translatorPair, .intNOut);

// >>> msps_sequencer_tb.sv
`timescale 1ns/1ps
`include "msps_regs.vh"
module msps_sequencer_tb;
  reg         clk = 1'h0, resetn = 1'h0, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  reg  [7:0]  wb_adr_i = 8'h0;
  reg  [31:0] wb_dat_i = 32'h0, rd, v;
  reg         conversionTriggerN = 1'h1, lastStart = 1'h0;
  reg  [11:0] logicInputLevel = 12'h0, overcurrent = 12'h0;
  wire [3:0]  wb_sel_i = 4'hf;
  wire [31:0] wb_dat_o;
  wire        wb_ack_o, adcStart, adcRefSel, adcDiff, dacLoad, intNOut, intNOe;
  wire [3:0]  adcPort, dacPort;
  wire [11:0] adcSample, dacCode, logicOutputState;
  wire [10:0] translatorPair;
  wire        intNIn = intNOe ? intNOut : 1'h1; // Pulled up unless sunk
  integer     fails = 0, check_count = 0, seed = 32'hbf45, i;
  int         rateCycles[4] = '{200, 160, 120, 100};
  int         q[$];
  time        tq[$];
  msps_sequencer u_dut (.clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .conversionTriggerN, .adcStart, .adcPort, .adcRefSel,
    .adcDiff, .adcSample, .dacLoad, .dacPort, .dacCode, .logicInputLevel, .logicOutputState,
    .overcurrent, .translatorPair, .intNIn, .intNOut, .intNOe);
  msps_adc_model u_adc (.clk, .adcStart, .adcPort, .adcSample);
  initial forever #12.5 clk = ~clk;
  // Slot log; port 5 alone uses the second reference
  always @(posedge clk) begin
    if (lastStart)
      chk(adcRefSel, adcPort == 4'h5);
    if (lastStart)
      chk(adcDiff, adcPort == 4'h5);
    lastStart = adcStart === 1'h1;
    if (lastStart) begin
      q.push_back(adcPort);
      tq.push_back($time);
    end
  end
  task chk(input [31:0] g, input [31:0] x);
    check_count = check_count + 1;
    if (g !== x) begin
      fails = fails + 1;
      $display("MISMATCH %0t got %h expected %h", $time, g, x);
    end
  endtask
  // Classic cycle: held until ack is sampled, then one idle cycle
  task wb(input w, input [7:0] a, input [31:0] d);
    integer k;
    k = 0;
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk);
      k = k + 1;
    end while (wb_ack_o !== 1'h1 && k < 50);
    if (wb_ack_o !== 1'h1)
      fails = fails + 1;
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    @(posedge clk);
  endtask
  // Waits past k slot starts, then lets the slot settle
  task waitStarts(input integer k);
    integer c;
    c = 0;
    while (k > 0 && c < 3000) begin
      @(posedge clk);
      c = c + 1;
      if (adcStart === 1'h1)
        k = k - 1;
    end
    if (k > 0)
      fails = fails + 1;
    repeat (20) @(posedge clk);
  endtask
  task sweep;
    conversionTriggerN <= 1'h0; // held far past 0.5 us
    waitStarts(2);
    conversionTriggerN <= 1'h1;
    repeat (200) @(posedge clk);
  endtask
  task waitPort(input [3:0] p);
    integer k;
    k = 0;
    do begin
      @(posedge clk);
      k = k + 1;
    end while ((dacLoad !== 1'h1 || (p != 4'hf && dacPort !== p)) && k < 6000);
    if (k >= 6000)
      fails = fails + 1;
  endtask
  task edgeStep(input [11:0] lvl, input e);
    logicInputLevel <= lvl;
    repeat (6) @(posedge clk);
    wb(1'h0, `MSPS_STATUS_ADDR, 32'h0);
    chk(rd[12], e);
    wb(1'h1, `MSPS_STATUS_ADDR, 32'h1000);
  endtask
  function [31:0] expAdc(input [3:0] p, input d);
    expAdc = {20'h0, p ^ {d, 3'h0}, 8'ha5};
  endfunction
  task results;
    $display("Checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Guard against a hang; the sequence needs about 16k cycles
  initial begin
    #2000000;
    fails = fails + 1;
    results();
  end
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'h1;
    @(posedge clk);
    wb(1'h0, `MSPS_CTRL_ADDR, 32'h0);
    chk(rd, 32'h0);
    // Ports 2, 5 convert, 7, 9 drive, 1 is a logic output
    wb(1'h1, 8'h48, 32'h21);
    wb(1'h1, 8'h54, 32'h79);
    wb(1'h1, 8'h5c, 32'h2);
    wb(1'h1, 8'h64, 32'h2);
    wb(1'h1, 8'h44, 32'h4);
    wb(1'h1, `MSPS_CTRL_ADDR, 32'h1);
    for (i = 1; i <= 8; i = i + 1) begin
      sweep();
      chk(q[q.size()-2], 2);
      chk(q[q.size()-1], 5);
      wb(1'h0, 8'hd4, 32'h0);
      chk(rd, i == 8 ? expAdc(5, 1) : 32'h0);
    end
    wb(1'h0, 8'hc8, 32'h0);
    chk(rd, expAdc(2, 0));
    wb(1'h1, `MSPS_CTRL_ADDR, 32'h0);
    wb(1'h0, 8'hc8, 32'h0);
    chk(rd, expAdc(2, 0));
    // Single conversion by soft trigger: port 2, port 5, then wrap to 2
    for (i = 0; i < 3; i = i + 1) begin
      wb(1'h1, `MSPS_CTRL_ADDR, 32'h22);
      repeat (250) @(posedge clk);
      chk(q[q.size()-1], i == 1 ? 5 : 2);
    end
    wb(1'h0, 8'hc8, 32'h0);
    chk(rd, expAdc(2, 0));
    wb(1'h1, `MSPS_CTRL_ADDR, 32'h3);
    wb(1'h0, 8'hc8, 32'h0);
    chk(rd, 32'h0);
    repeat (20) @(posedge clk);
    // Every rate in continuous mode; a held trigger must not disturb the spacing
    for (i = 0; i < 4; i = i + 1) begin
      wb(1'h1, `MSPS_CTRL_ADDR, 32'h3 | (i << 2));
      conversionTriggerN <= 1'h0;
      waitStarts(3);
      conversionTriggerN <= 1'h1;
      chk(tq[tq.size()-1] - tq[tq.size()-2], rateCycles[i] * 25);
    end
    // Jump on; port 7 rewritten just after its load must come round first
    wb(1'h1, `MSPS_CTRL_ADDR, 32'h10);
    waitPort(4'h7);
    v = $random(seed);
    wb(1'h1, 8'h9c, v); // lone jump write
    waitPort(4'hf);
    chk(dacPort, 7);
    chk(dacCode, v[11:0]);
    waitPort(4'hf);
    chk(dacPort, 9);
    v = $random(seed);
    wb(1'h1, `MSPS_PRESET1_ADDR, v);
    wb(1'h1, `MSPS_PRESETSEL_ADDR, 32'h80080);
    waitPort(4'h7);
    chk(dacCode, v[11:0]);
    overcurrent <= 12'h80;
    repeat (6) @(posedge clk);
    chk(intNOe, 0);
    wb(1'h0, `MSPS_STATUS_ADDR, 32'h0);
    chk(rd[11:0], 12'h80);
    wb(1'h1, `MSPS_MASK_ADDR, 32'h80);
    chk(intNOe, 1);
    overcurrent <= 12'h0;
    repeat (6) @(posedge clk);
    wb(1'h1, `MSPS_STATUS_ADDR, 32'h80);
    chk(intNOe, 0);
    // Port 0 as logic input under each edge choice: a rise, then a fall
    for (i = 0; i < 4; i = i + 1) begin
      wb(1'h1, 8'h40, 32'h3 | (i << 8));
      edgeStep(12'h1, i[0]);
      edgeStep(12'h0, i[1]);
    end
    v = $random(seed);
    wb(1'h1, `MSPS_GPOSTATE_ADDR, v);
    @(posedge clk);
    chk(logicOutputState, {v[1], 1'h0});
    wb(1'h1, 8'h80, v);
    waitPort(4'h0);
    chk(dacCode, v[11:0]);
    wb(1'h1, 8'h50, 32'h400);
    chk(translatorPair, 11'h10);
    wb(1'h1, 8'h54, 32'h400);
    chk(translatorPair, 11'h10);
    results();
  end
endmodule // msps_sequencer_tb
